// file: timer_pwm_unit.sv
module timer_pwm_unit (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire timer_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire timer_pkg::ext_in_t ext_i,
  output timer_pkg::wave_pins_t pins_o,
  output logic irq_o
);
  import timer_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] div;
    logic [7:0] src;
    logic [7:0] port;
    logic [7:0] cmp_wr;
    logic [7:0] rld_wr;
    logic [7:0] cmp_act;
    logic [7:0] rld_act;
    logic [15:0] pre_cnt;
    logic [7:0] cnt;
    logic wave;
    edge_state_t edge_st;
    logic clk_d;
    logic start_d;
    logic clear_d;
    logic running;
    logic [7:0] rdata;
    logic irq;
    logic oe;
    logic oe_n;
  } st_t;

  localparam st_t ST_RST = '{
    mode: MODE_RST, div: DIV_RST, src: SRC_RST,
    port: PORT_RST, cmp_wr: CMP_RST,
    rld_wr: RLD_RST, cmp_act: CMP_RST,
    rld_act: RLD_RST, pre_cnt: 16'h0000,
    cnt: 8'h00, wave: 1'b0, edge_st: EDGE_WAIT,
    clk_d: 1'b0, start_d: 1'b0, clear_d: 1'b0,
    running: 1'b0, rdata: 8'h00, irq: 1'b0,
    oe: 1'b0, oe_n: 1'b0};

  st_t st_reg; // Registered state
  st_t st_next; // Next state

  // Helper terms
  logic pwm; // PWM mode selected
  logic clr; // Counter clear this cycle
  logic hold; // Unit held in clear (level)
  logic src_tick; // Selected clock tick
  logic tick; // Divider tick
  logic run; // Counting enabled
  logic stop_evt; // Timer just stopped
  logic [4:0] ratio; // Clamped divider code
  logic [15:0] mask; // Prescaler tap mask
  logic [7:0] half; // Square wave half period
  logic use_ic, use_ec, use_ir, use_er;
  logic clr_ext, run_ext;
  logic w_rise, w_fall;

  // ----------------------------------------
  // Next state logic
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.rdata = 8'h00;
    pwm = st_reg.mode[MB_PWM];

    // Clear terms first, as the flags read uses hold
    // Clear source decode, 11 acts internal
    use_ec = (st_reg.src[SB_CLR+:2] == SRC_EXT)
      || (st_reg.src[SB_CLR+:2] == SRC_BOTH);
    use_ic = (st_reg.src[SB_CLR+:2] != SRC_EXT);
    clr_ext = st_reg.mode[MB_CLR_EDGE]
      ? (ext_i.ext_clear & ~st_reg.clear_d)
      : ext_i.ext_clear;
    // Soft clear bit low holds clear unless the clear source is SRC_EXT
    hold = (use_ic & ~st_reg.mode[MB_SOFT_CLR])
      | (use_ec & ~st_reg.mode[MB_CLR_EDGE]
         & ext_i.ext_clear);
    clr = (use_ic & ~st_reg.mode[MB_SOFT_CLR])
      | (use_ec & clr_ext);

    // Register writes
    if (req_i.wr) begin
      if (req_i.addr == ADDR_MODE) begin
        st_next.mode = req_i.wdata;
      end else if (req_i.addr == ADDR_DIV) begin
        st_next.div = req_i.wdata;
      end else if (req_i.addr == ADDR_SRC) begin
        st_next.src = req_i.wdata & SRC_MASK;
      end else if (req_i.addr == ADDR_CMP) begin
        st_next.cmp_wr = req_i.wdata;
      end else if (req_i.addr == ADDR_RLD) begin
        st_next.rld_wr = req_i.wdata;
      end else if (req_i.addr == ADDR_PORT) begin
        st_next.port = req_i.wdata;
      end
    end

    // Register reads, data next cycle
    if (req_i.rd) begin
      if (req_i.addr == ADDR_MODE) begin
        st_next.rdata = st_reg.mode;
      end else if (req_i.addr == ADDR_DIV) begin
        st_next.rdata = st_reg.div;
      end else if (req_i.addr == ADDR_SRC) begin
        st_next.rdata = st_reg.src;
      end else if (req_i.addr == ADDR_CMP) begin
        st_next.rdata = st_reg.cmp_wr;
      end else if (req_i.addr == ADDR_RLD) begin
        st_next.rdata = st_reg.rld_wr;
      end else if (req_i.addr == ADDR_PORT) begin
        st_next.rdata = st_reg.port;
      end else if (req_i.addr == ADDR_COUNT) begin
        st_next.rdata = st_reg.cnt;
      end else begin
        st_next.rdata = {3'h0, st_reg.edge_st,
          hold, st_reg.wave, st_reg.running};
      end
    end

    // Input edge history
    st_next.clk_d = ext_i.ext_timer_clock;
    st_next.start_d = ext_i.ext_start_stop;
    st_next.clear_d = ext_i.ext_clear;

    // Divide by two to the code
    ratio = (st_reg.div[DB_RATIO+:5] > RATIO_MAX)
      ? RATIO_MAX : st_reg.div[DB_RATIO+:5];
    mask = 16'hffff >> (RATIO_MAX - ratio);
    // External clock edges need two cycles
    src_tick = st_reg.src[SB_CLK]
      ? (ext_i.ext_timer_clock & ~st_reg.clk_d)
      : 1'b1;
    tick = src_tick & ((st_reg.pre_cnt & mask) == mask);
    if (clr) begin
      st_next.pre_cnt = 16'h0000;
    end else if (src_tick) begin
      st_next.pre_cnt = st_reg.pre_cnt + 16'h0001;
    end

    if (clr) begin
      st_next.edge_st = EDGE_WAIT;
    end else if (ext_i.ext_start_stop & ~st_reg.start_d) begin
      case (st_reg.edge_st)
        EDGE_WAIT: st_next.edge_st = EDGE_COUNT;
        EDGE_COUNT: st_next.edge_st = EDGE_DONE;
        default: st_next.edge_st = EDGE_DONE;
      endcase
    end

    use_er = (st_reg.src[SB_RUN+:2] == SRC_EXT)
      || (st_reg.src[SB_RUN+:2] == SRC_BOTH);
    use_ir = (st_reg.src[SB_RUN+:2] != SRC_EXT);
    run_ext = st_reg.mode[MB_RUN_EDGE]
      ? (st_reg.edge_st == EDGE_COUNT)
      : ext_i.ext_start_stop;
    run = pwm | (use_ir & st_reg.mode[MB_SOFT_RUN])
      | (use_er & run_ext);
    st_next.running = run & ~clr;
    stop_evt = st_reg.running & ~run & ~pwm;

    // Counter stage
    if (clr) begin
      st_next.cnt = 8'h00;
      st_next.cmp_act = st_reg.cmp_wr;
      st_next.rld_act = st_reg.rld_wr;
    end else if (run & tick) begin
      if (pwm) begin
        if (st_reg.cnt >= PWM_TOP) begin
          st_next.cnt = st_reg.rld_wr;
          st_next.cmp_act = st_reg.cmp_wr;
          st_next.rld_act = st_reg.rld_wr;
        end else begin
          st_next.cnt = st_reg.cnt + 8'h01;
        end
      end else begin
        if (st_reg.cnt == st_reg.cmp_act - 8'h01) begin
          st_next.cnt = 8'h00;
          st_next.cmp_act = st_reg.cmp_wr;
        end else begin
          st_next.cnt = st_reg.cnt + 8'h01;
        end
      end
    end else if (~run & (st_reg.cnt == 8'h00)) begin
      // Idle at zero: no phase in progress
      st_next.cmp_act = st_reg.cmp_wr;
      st_next.rld_act = st_reg.rld_wr;
    end

    // Waveform from the next count
    half = (st_next.cmp_act == 8'h00) ? 8'h80
      : {1'b0, st_next.cmp_act[7:1]};
    if (pwm) begin
      // 255 always high, high below compare, low from compare up
      st_next.wave = st_next.cnt < st_next.cmp_act;
    end else if (st_reg.div[DB_SHAPE]) begin
      st_next.wave = st_next.cnt < half;
    end else begin
      st_next.wave = run & ~clr & (st_next.cnt == 8'h00);
    end

    w_rise = st_next.wave & ~st_reg.wave;
    w_fall = ~st_next.wave & st_reg.wave;
    if (st_reg.mode[MB_IRQ_SRC]) begin
      case (st_reg.mode[MB_IRQ_EDGE+:2])
        IRQ_FALL: st_next.irq = w_fall;
        IRQ_RISE: st_next.irq = w_rise;
        IRQ_BOTH: st_next.irq = w_rise | w_fall;
        default: st_next.irq = 1'b0;
      endcase
    end else begin
      st_next.irq = stop_evt;
    end

    st_next.oe = ~hold & ~st_reg.port[PB_WAVE];
    st_next.oe_n = ~hold & ~st_reg.port[PB_WAVE_N];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign pins_o.wave_pin = st_reg.wave;
  assign pins_o.wave_pin_oe = st_reg.oe;
  assign pins_o.wave_pin_inverted = ~st_reg.wave;
  assign pins_o.wave_pin_inverted_oe = st_reg.oe_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_clear_zero: assert property (
    clr |=> st_reg.cnt == 8'h00)
    else $error("counter not zero after clear");
  chk_pin_float: assert property (
    hold |=> !pins_o.wave_pin_oe)
    else $error("pin driven while held");
  chk_div_one: assert property (
    (ratio == 5'h00 && !st_reg.src[SB_CLK]) |-> tick)
    else $error("divide by one missed tick");
  chk_tick_step: assert property (
    (!clr && run && tick && !pwm
     && st_reg.cnt != st_reg.cmp_act - 8'h01)
    |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
    else $error("counter did not step");
  chk_pwm_reload: assert property (
    (!clr && pwm && tick && st_reg.cnt >= PWM_TOP)
    |=> st_reg.cnt == $past(st_reg.rld_wr))
    else $error("reload not applied");
  chk_pwm_full: assert property (
    (pwm && st_reg.cmp_act == CMP_FULL) |-> st_reg.wave)
    else $error("full compare not high");
  chk_soft_stop: assert property (
    (!pwm && !clr && st_reg.src[SB_RUN+:2] == SRC_INT
     && !st_reg.mode[MB_SOFT_RUN])
    |=> $stable(st_reg.cnt))
    else $error("counted while stopped");
  chk_stop_irq: assert property (
    (stop_evt && !st_reg.mode[MB_IRQ_SRC]) |=> irq_o)
    else $error("stop interrupt missing");
  chk_level_run: assert property (
    (!pwm && !clr && st_reg.src[SB_RUN+:2] == SRC_EXT
     && !st_reg.mode[MB_RUN_EDGE] && !ext_i.ext_start_stop)
    |=> $stable(st_reg.cnt))
    else $error("counted with start low");

  // ----------------------------------------
  // Sequencing, edge and pin checks
  // ----------------------------------------
  // Prescaler restarts with every clear
  chk_pre_clear: assert property (
    clr |=> st_reg.pre_cnt == 16'h0000)
    else $error("prescaler not cleared");
  // Mid-phase timer steps keep the active compare
  chk_cmp_hold: assert property (
    (!pwm && !clr && run && tick
     && st_reg.cnt != st_reg.cmp_act - 8'h01)
    |=> $stable(st_reg.cmp_act))
    else $error("compare changed mid phase");
  // Zero compare keeps the PWM wave low
  chk_pwm_zero: assert property (
    (pwm && st_reg.cmp_act == 8'h00 && st_reg.cmp_wr == 8'h00)
    |=> !st_reg.wave)
    else $error("zero compare not low");
  // Rising-edge interrupt follows every wave rise
  chk_irq_rise: assert property (
    (st_reg.mode[MB_IRQ_SRC] && st_reg.mode[MB_IRQ_EDGE+:2] == IRQ_RISE
     && !st_reg.wave) |=> irq_o == st_reg.wave)
    else $error("rise interrupt wrong");
  // Falling-edge interrupt follows every wave fall
  chk_irq_fall: assert property (
    (st_reg.mode[MB_IRQ_SRC] && st_reg.mode[MB_IRQ_EDGE+:2] == IRQ_FALL
     && st_reg.wave) |=> irq_o == !st_reg.wave)
    else $error("fall interrupt wrong");
  // Second input rise ends the period count
  chk_edge_done: assert property (
    (!clr && st_reg.edge_st == EDGE_COUNT
     && ext_i.ext_start_stop && !st_reg.start_d)
    |=> st_reg.edge_st == EDGE_DONE)
    else $error("period count not ended");
  // Edge start counts only between the two rises
  chk_edge_stop: assert property (
    (!pwm && !clr && st_reg.src[SB_RUN+:2] == SRC_EXT
     && st_reg.mode[MB_RUN_EDGE] && st_reg.edge_st != EDGE_COUNT)
    |=> $stable(st_reg.cnt))
    else $error("counted outside period");
  // A zero config bit drives the pin once released
  chk_oe_enable: assert property (
    (!hold && !st_reg.port[PB_WAVE]) |=> pins_o.wave_pin_oe)
    else $error("pin not driven");
endmodule

// file: timer_pkg.sv
package timer_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_DIV = 3'h1;
  localparam logic [2:0] ADDR_SRC = 3'h2;
  localparam logic [2:0] ADDR_CMP = 3'h3;
  localparam logic [2:0] ADDR_RLD = 3'h4;
  localparam logic [2:0] ADDR_PORT = 3'h5;
  localparam logic [2:0] ADDR_COUNT = 3'h6;
  localparam logic [2:0] ADDR_STAT = 3'h7;
  // ----------------------------------------
  // Reset values and source write mask
  // ----------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] RLD_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h03;
  localparam logic [7:0] SRC_MASK = 8'h1f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MB_SOFT_CLR = 0;
  localparam int MB_CLR_EDGE = 1;
  localparam int MB_SOFT_RUN = 2;
  localparam int MB_RUN_EDGE = 3;
  localparam int MB_IRQ_EDGE = 4;
  localparam int MB_IRQ_SRC = 6;
  localparam int MB_PWM = 7;
  localparam int DB_RATIO = 0;
  localparam int DB_SHAPE = 5;
  localparam int SB_CLR = 0;
  localparam int SB_RUN = 2;
  localparam int SB_CLK = 4;
  localparam int PB_WAVE = 0;
  localparam int PB_WAVE_N = 1;
  // ----------------------------------------
  // Codes and limits
  // ----------------------------------------
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_BOTH = 2'h2;
  localparam logic [1:0] IRQ_FALL = 2'h0;
  localparam logic [1:0] IRQ_RISE = 2'h1;
  localparam logic [1:0] IRQ_BOTH = 2'h2;
  localparam logic [4:0] RATIO_MAX = 5'h10;
  localparam logic [7:0] PWM_TOP = 8'hfe;
  localparam logic [7:0] CMP_FULL = 8'hff;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    EDGE_WAIT, EDGE_COUNT, EDGE_DONE
  } edge_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic ext_timer_clock;
    logic ext_start_stop;
    logic ext_clear;
  } ext_in_t;
  typedef struct packed {
    logic wave_pin;
    logic wave_pin_oe;
    logic wave_pin_inverted;
    logic wave_pin_inverted_oe;
  } wave_pins_t;
endpackage

// file: ext_side_model.sv
// Far side of the timer: external clock, run and clear lines
module ext_side_model (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic clk_run_i,
  input wire logic start_i,
  input wire logic clear_i,
  output timer_pkg::ext_in_t ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  // Phase of the slow external clock
  logic phase_reg;
  // ----------------------------------------
  // Line drivers
  // ----------------------------------------
  // Clock at a quarter rate, still when idle
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      phase_reg <= 1'b0;
      ext_o <= '0;
    end else begin
      phase_reg <= !phase_reg;
      // Toggle every second cycle, else park low
      if (!clk_run_i) begin
        ext_o.ext_timer_clock <= 1'b0;
      end else if (phase_reg) begin
        ext_o.ext_timer_clock <= !ext_o.ext_timer_clock;
      end
      ext_o.ext_start_stop <= start_i;
      ext_o.ext_clear <= clear_i;
    end
  end
endmodule

// file: prescaled_timer_pwm_unit_tb.sv
module prescaled_timer_pwm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  // Clock, reset and bus
  logic mclk_i;
  logic rst_b_i;
  reg_req_t req;
  logic [7:0] rdata_o;
  // Far side lines and pins
  ext_in_t ext;
  wave_pins_t pins;
  logic irq_o;
  logic clk_run;
  logic start;
  logic clear;
  int n_errors = 0;
  int samples_checked = 0;
  timer_pwm_unit timer_pwm_unit_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .req_i(req), .rdata_o(rdata_o), .ext_i(ext), .pins_o(pins),
    .irq_o(irq_o));
  ext_side_model ext_side_model_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .clk_run_i(clk_run), .start_i(start), .clear_i(clear), .ext_o(ext));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Free-running clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req <= '0;
    #1 d = rdata_o;
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp8(d, e);
  endtask
  // Counts cycles while the wave holds a level, capped at 600
  task automatic run_while(input logic v, output int n);
    n = 0;
    while (pins.wave_pin === v && n < 600) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  // High time and period of the wave from one rise
  task automatic measure(output int hi, output int per);
    int lo;
    @(negedge mclk_i);
    // Skip the first period, which a start or mode change may cut
    run_while(1'b0, lo);
    run_while(1'b1, lo);
    run_while(1'b0, lo);
    run_while(1'b1, hi);
    run_while(1'b0, lo);
    per = hi + lo;
  endtask
  // Counts interrupt pulses over 30 cycles
  task automatic count_irq(output int n);
    n = 0;
    repeat (30) begin
      @(negedge mclk_i);
      if (irq_o === 1'b1) n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_rd(ADDR_MODE, MODE_RST);
    chk_rd(ADDR_DIV, DIV_RST);
    chk_rd(ADDR_SRC, SRC_RST);
    chk_rd(ADDR_PORT, PORT_RST);
    cmp8({6'h0, pins.wave_pin_oe, pins.wave_pin_inverted_oe}, 8'h00);
    wr(ADDR_SRC, 8'hff);
    chk_rd(ADDR_SRC, SRC_MASK);
    wr(ADDR_COUNT, 8'h5a);
    chk_rd(ADDR_COUNT, 8'h00);
    wr(ADDR_SRC, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_pulse();
    int hi, per, n;
    wr(ADDR_DIV, 8'h01);
    wr(ADDR_CMP, 8'h03);
    wr(ADDR_PORT, 8'h00);
    wr(ADDR_MODE, 8'h55);
    measure(hi, per);
    cmp32(hi, 2);
    cmp32(per, 6);
    cmp8({6'h0, pins.wave_pin_oe, pins.wave_pin_inverted_oe}, 8'h03);
    cmp8({7'h0, pins.wave_pin_inverted}, {7'h0, !pins.wave_pin});
    count_irq(n);
    cmp32(n, 5);
    $display("pulse test done");
  endtask
  task automatic t_irq();
    int n;
    // Both edges of the running pulse wave
    wr(ADDR_MODE, 8'h65);
    repeat (12) @(posedge mclk_i);
    count_irq(n);
    cmp32(n, 10);
    // Falling edges only
    wr(ADDR_MODE, 8'h45);
    repeat (12) @(posedge mclk_i);
    count_irq(n);
    cmp32(n, 5);
    $display("irq test done");
  endtask
  task automatic t_square_ext();
    int hi, per;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_SRC, 8'h10);
    wr(ADDR_DIV, 8'h20);
    wr(ADDR_CMP, 8'h02);
    clk_run <= 1'b1;
    wr(ADDR_MODE, 8'h05);
    measure(hi, per);
    cmp32(hi, 4);
    cmp32(per, 8);
    clk_run <= 1'b0;
    wr(ADDR_SRC, 8'h00);
    $display("square test done");
  endtask
  task automatic t_pwm();
    int hi, per;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_DIV, 8'h00);
    wr(ADDR_RLD, 8'hfa);
    wr(ADDR_CMP, 8'hfc);
    wr(ADDR_MODE, 8'h81);
    measure(hi, per);
    cmp32(hi, 2);
    cmp32(per, 5);
    wr(ADDR_CMP, CMP_FULL);
    repeat (12) @(posedge mclk_i);
    run_while(1'b1, hi);
    cmp32(hi, 600);
    wr(ADDR_CMP, 8'h00);
    repeat (12) @(posedge mclk_i);
    run_while(1'b0, hi);
    cmp32(hi, 600);
    $display("pwm test done");
  endtask
  task automatic t_level();
    int k;
    logic [7:0] d;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_SRC, 8'h04);
    wr(ADDR_MODE, 8'h01);
    start <= 1'b1;
    repeat (20) @(posedge mclk_i);
    start <= 1'b0;
    k = 0;
    while (irq_o !== 1'b1 && k < 10) begin
      @(negedge mclk_i);
      k++;
    end
    cmp8({7'h0, irq_o}, 8'h01);
    repeat (4) @(posedge mclk_i);
    chk_rd(ADDR_COUNT, 8'h14);
    rd(ADDR_STAT, d);
    cmp8({7'h0, d[0]}, 8'h00);
    $display("level test done");
  endtask
  task automatic t_edge();
    logic [7:0] d;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h09);
    start <= 1'b1;
    repeat (2) @(posedge mclk_i);
    start <= 1'b0;
    repeat (10) @(posedge mclk_i);
    start <= 1'b1;
    repeat (2) @(posedge mclk_i);
    start <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk_rd(ADDR_COUNT, 8'h0c);
    rd(ADDR_STAT, d);
    cmp8({6'h0, d[4:3]}, 8'h02);
    $display("edge test done");
  endtask
  task automatic t_clear();
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_SRC, 8'h01);
    wr(ADDR_MODE, 8'h05);
    repeat (10) @(posedge mclk_i);
    clear <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_rd(ADDR_COUNT, 8'h00);
    cmp8({7'h0, pins.wave_pin_oe}, 8'h00);
    @(posedge mclk_i);
    clear <= 1'b0;
    $display("clear test done");
  endtask
  task automatic t_edge_clear();
    // External clear acts on its rise only, counting goes on
    wr(ADDR_MODE, 8'h06);
    clear <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk_rd(ADDR_COUNT, 8'h09);
    cmp8({7'h0, pins.wave_pin_oe}, 8'h01);
    clear <= 1'b0;
    $display("edge clear test done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    req = '0;
    clk_run = 1'b0;
    start = 1'b0;
    clear = 1'b0;
    rst_b_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_pulse();
    t_irq();
    t_square_ext();
    t_pwm();
    t_level();
    t_edge();
    t_clear();
    t_edge_clear();
    end_of_test();
  end
  // Cuts a hang short
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule
